// File: hps_defs.svh
// Register offsets, field positions, reset values and timing figures of the slot pin block
`ifndef HPS_DEFS_SVH
`define HPS_DEFS_SVH

// Register byte offsets
`define HPS_OFF_CFG 12'h408
`define HPS_OFF_CTL 12'h500
`define HPS_OFF_CMD 12'h504
`define HPS_OFF_STS_IN 12'h508
`define HPS_OFF_STS_SLOT 12'h50c

// Configuration register fields
`define HPS_CFG_INV_BUTTON 0
`define HPS_CFG_INV_PRESENCE 1
`define HPS_CFG_INV_FAULT 2
`define HPS_CFG_INV_LATCH 3
`define HPS_CFG_INV_ATTN 4
`define HPS_CFG_INV_PWR_IND 5
`define HPS_CFG_INV_PWR_EN 6
`define HPS_CFG_INV_ILOCK 7
`define HPS_CFG_INV_PGOOD 8
`define HPS_CFG_LATCH_PWR_OFF 11
`define HPS_CFG_LATCH_AS_LOCK 12
`define HPS_CFG_ILOCK_TOGGLE 13
`define HPS_CFG_RST_SRC_LO 14
`define HPS_CFG_RST_SRC_HI 15
`define HPS_CFG_P2R_LO 16
`define HPS_CFG_P2R_HI 23
`define HPS_CFG_R2P_LO 24
`define HPS_CFG_R2P_HI 31
`define HPS_CFG_RESET 32'h1414_0800

// Control register byte lanes
`define HPS_CTL_PCC_LO 0
`define HPS_CTL_LATCHP_LO 8
`define HPS_CTL_ATTN_LO 16
`define HPS_CTL_HOTRST_LO 24
`define HPS_CTL_RESET 32'h0000_0000

// Reset source codes
`define HPS_RST_SRC_PEC 2'h0
`define HPS_RST_SRC_PGC 2'h1
`define HPS_RST_SRC_HOT 2'h2

// Timing
`define HPS_CLK_KHZ 125000
`define HPS_TICK_MS 10
`define HPS_TICK_CYCLES (`HPS_TICK_MS * `HPS_CLK_KHZ)
`define HPS_ILOCK_PULSE_MS 125
`define HPS_ILOCK_PULSE_TICKS ((`HPS_ILOCK_PULSE_MS + `HPS_TICK_MS - 1) / `HPS_TICK_MS)

`endif

// File: hps_pkg.sv
// Types shared by the slot pin block
package hps_pkg;
  typedef enum logic [2:0] {
    SLOT_OFF,
    SLOT_RAMP,
    SLOT_P2R,
    SLOT_ON,
    SLOT_R2P
  } hps_slot_state_e;
  typedef logic [7:0] hps_delay_t;
  typedef logic [1:0] hps_rst_src_t;
  typedef logic [7:0] hps_pulse_t;
endpackage : hps_pkg

// File: hps_slot_port.sv
// Per-port power, reset and interlock sequencer
`include "hps_defs.svh"
module hps_slot_port #(
  parameter int PULSE_TICKS = `HPS_ILOCK_PULSE_TICKS
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Timebase and configuration
  input wire logic tick,
  input wire hps_pkg::hps_rst_src_t rst_src,
  input wire hps_pkg::hps_delay_t p2r_delay,
  input wire hps_pkg::hps_delay_t r2p_delay,
  input wire logic ilock_toggle,
  // Slot requests and sense
  input wire logic want_power,
  input wire logic power_good,
  input wire logic hot_reset,
  input wire logic ilock_cmd,
  // Logical slot state
  output logic power_on,
  output logic reset_active,
  output logic ilock_level
);
  hps_pkg::hps_slot_state_e state_r, state_nxt;
  hps_pkg::hps_delay_t cnt_r, cnt_nxt;
  hps_pkg::hps_pulse_t pcnt_r, pcnt_nxt;
  logic ilock_r, ilock_nxt;
  logic pulsing_r, pulsing_nxt;
  logic stable;

  // Reserved source code behaves as power enable
  assign stable = (rst_src == `HPS_RST_SRC_PGC) ? power_good : 1'b1;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      hps_pkg::SLOT_OFF: begin
        if (want_power) begin
          state_nxt = hps_pkg::SLOT_RAMP;
        end
      end
      hps_pkg::SLOT_RAMP: begin
        if (!want_power) begin
          state_nxt = hps_pkg::SLOT_OFF;
        end else if (stable) begin
          cnt_nxt = p2r_delay;
          state_nxt = hps_pkg::SLOT_P2R;
        end
      end
      hps_pkg::SLOT_P2R: begin
        // Reset was never released, so power may drop at once
        if (!want_power) begin
          state_nxt = hps_pkg::SLOT_OFF;
        end else if (!stable) begin
          state_nxt = hps_pkg::SLOT_RAMP;
        end else if (cnt_r == 8'h00) begin
          state_nxt = hps_pkg::SLOT_ON;
        end else if (tick) begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      hps_pkg::SLOT_ON: begin
        if (!want_power) begin
          cnt_nxt = r2p_delay;
          state_nxt = hps_pkg::SLOT_R2P;
        end else if (!stable) begin
          state_nxt = hps_pkg::SLOT_RAMP;
        end
      end
      hps_pkg::SLOT_R2P: begin
        if (cnt_r == 8'h00) begin
          state_nxt = hps_pkg::SLOT_OFF;
        end else if (tick) begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      default: begin
        state_nxt = hps_pkg::SLOT_OFF;
      end
    endcase
  end

  always_comb begin
    ilock_nxt = ilock_r;
    pulsing_nxt = pulsing_r;
    pcnt_nxt = pcnt_r;
    if (ilock_cmd) begin
      if (ilock_toggle) begin
        ilock_nxt = ~ilock_r;
      end else begin
        ilock_nxt = 1'b1;
        pulsing_nxt = 1'b1;
        pcnt_nxt = hps_pkg::hps_pulse_t'(PULSE_TICKS);
      end
    end else if (pulsing_r) begin
      if (pcnt_r == 8'h00) begin
        ilock_nxt = 1'b0;
        pulsing_nxt = 1'b0;
      end else if (tick) begin
        pcnt_nxt = pcnt_r - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= hps_pkg::SLOT_OFF;
      cnt_r <= 8'h00;
      pcnt_r <= 8'h00;
      ilock_r <= 1'b0;
      pulsing_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pcnt_r <= pcnt_nxt;
      ilock_r <= ilock_nxt;
      pulsing_r <= pulsing_nxt;
    end
  end

  assign power_on = (state_r != hps_pkg::SLOT_OFF);
  assign reset_active = (state_r != hps_pkg::SLOT_ON) ||
                        ((rst_src == `HPS_RST_SRC_HOT) && hot_reset);
  assign ilock_level = ilock_r;
endmodule : hps_slot_port

// File: hps_pin_ctrl.sv
// Hot-plug slot pin control: APB registers, pin polarity and per-port sequencers
//
// What this block does
// - Button, presence and fault inputs are inverted when their invert bit is set.
// - Latch sensor and power good inputs are inverted when their invert bit is set.
// - Attention, power indicator, power enable and interlock outputs invert; bit 7 interlock.
// - Latch open removes slot power when auto power-off and latch-present are set.
// - That automatic power removal ignores the software power controller control bit.
// - Latch-status replacement bit turns latch sensor inputs into lock state inputs.
// - Toggle-select clear: interlock command write of one pulses interlock for 125 ms.
// - Toggle-select set: each interlock command write of one flips the interlock output.
// - Reset source field picks power enable, power good or hot reset; one reserved.
// - Port reset releases power-to-reset times 10 ms after power is stable.
// - Power turns off reset-to-power times 10 ms after the port reset asserts.
`include "hps_defs.svh"
module hps_pin_ctrl #(
  parameter int NPORTS = 6,
  parameter int TICK_CYCLES = `HPS_TICK_CYCLES,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Slot sense pins
  input wire logic [NPORTS-1:0] attention_button_input,
  input wire logic [NPORTS-1:0] presence_detect_input,
  input wire logic [NPORTS-1:0] power_fault_input,
  input wire logic [NPORTS-1:0] retention_latch_sensor_input,
  input wire logic [NPORTS-1:0] slot_power_good_input,
  // Slot drive pins
  output logic [NPORTS-1:0] attention_indicator_output,
  output logic [NPORTS-1:0] power_indicator_output,
  output logic [NPORTS-1:0] slot_power_enable_output,
  output logic [NPORTS-1:0] interlock_drive_output,
  output logic [NPORTS-1:0] port_reset_n
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_CFG = 3'h1;
  localparam logic [2:0] SEL_CTL = 3'h2;
  localparam logic [2:0] SEL_CMD = 3'h3;
  localparam logic [2:0] SEL_STS_IN = 3'h4;
  localparam logic [2:0] SEL_STS_SLOT = 3'h5;

  // Address decode shared by the write and read paths
  function automatic logic [2:0] reg_decode(input logic [ADDR_W-1:0] a);
    logic [11:0] off;
    off = 12'(a);
    if (off == `HPS_OFF_CFG) begin
      reg_decode = SEL_CFG;
    end else if (off == `HPS_OFF_CTL) begin
      reg_decode = SEL_CTL;
    end else if (off == `HPS_OFF_CMD) begin
      reg_decode = SEL_CMD;
    end else if (off == `HPS_OFF_STS_IN) begin
      reg_decode = SEL_STS_IN;
    end else if (off == `HPS_OFF_STS_SLOT) begin
      reg_decode = SEL_STS_SLOT;
    end else begin
      reg_decode = SEL_NONE;
    end
  endfunction : reg_decode

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    lane_merge = res;
  endfunction : lane_merge

  // Widen a per-port vector to one status byte
  function automatic logic [7:0] to_byte(input logic [NPORTS-1:0] v);
    logic [7:0] res;
    res = 8'h00;
    for (int p = 0; p < NPORTS; p++) begin
      res[p] = v[p];
    end
    to_byte = res;
  endfunction : to_byte

  // Bus state
  logic [31:0] cfg_r, cfg_nxt;
  logic [31:0] ctl_r, ctl_nxt;
  logic [NPORTS-1:0] eic_r, eic_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [2:0] sel;
  logic commit;

  // Timebase state
  logic [TW-1:0] tick_cnt_r, tick_cnt_nxt;
  logic tick_r, tick_nxt;

  // Pin state
  logic [NPORTS-1:0] attn_pin_r, attn_pin_nxt;
  logic [NPORTS-1:0] pind_pin_r, pind_pin_nxt;
  logic [NPORTS-1:0] pen_pin_r, pen_pin_nxt;
  logic [NPORTS-1:0] ilock_pin_r, ilock_pin_nxt;
  logic [NPORTS-1:0] prst_n_r, prst_n_nxt;

  // Sensed and logical slot signals
  logic [NPORTS-1:0] button_act;
  logic [NPORTS-1:0] presence_act;
  logic [NPORTS-1:0] fault_act;
  logic [NPORTS-1:0] latch_act;
  logic [NPORTS-1:0] latch_open;
  logic [NPORTS-1:0] lock_engaged;
  logic [NPORTS-1:0] pgood_act;
  logic [NPORTS-1:0] want_power;
  logic [NPORTS-1:0] power_on;
  logic [NPORTS-1:0] reset_active;
  logic [NPORTS-1:0] ilock_level;

  assign sel = reg_decode(paddr);
  // A write lands only on the edge where the master sees pready high
  assign commit = psel && penable && pready_r;

  always_comb begin
    cfg_nxt = cfg_r;
    ctl_nxt = ctl_r;
    eic_nxt = '0;
    pready_nxt = 1'b0;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (commit && pwrite) begin
      if (sel == SEL_CFG) begin
        cfg_nxt = lane_merge(cfg_r, pwdata, pstrb);
      end else if (sel == SEL_CTL) begin
        ctl_nxt = lane_merge(ctl_r, pwdata, pstrb);
      end else if (sel == SEL_CMD && pstrb[0]) begin
        eic_nxt = pwdata[NPORTS-1:0];
      end
    end
    // One wait state: pready rises in the second access cycle
    if (psel && penable && !pready_r) begin
      pready_nxt = 1'b1;
      pslverr_nxt = (sel == SEL_NONE);
      unique case (sel)
        SEL_CFG: prdata_nxt = cfg_r;
        SEL_CTL: prdata_nxt = ctl_r;
        SEL_STS_IN: prdata_nxt = {to_byte(latch_act), to_byte(fault_act),
                                  to_byte(presence_act), to_byte(button_act)};
        SEL_STS_SLOT: prdata_nxt = {to_byte(ilock_level), to_byte(reset_active),
                                    to_byte(power_on), to_byte(pgood_act)};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_r <= `HPS_CFG_RESET;
      ctl_r <= `HPS_CTL_RESET;
      eic_r <= '0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      ctl_r <= ctl_nxt;
      eic_r <= eic_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Free-running 10 ms tick; the first tick of a delay may come early by up to one period
  always_comb begin
    tick_nxt = 1'b0;
    tick_cnt_nxt = tick_cnt_r + TW'(1);
    if (tick_cnt_r == TW'(TICK_CYCLES - 1)) begin
      tick_cnt_nxt = '0;
      tick_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Sense pins are active low; an invert bit flips the meaning
  assign button_act = ~(attention_button_input ^
                        {NPORTS{cfg_r[`HPS_CFG_INV_BUTTON]}});
  assign presence_act = ~(presence_detect_input ^
                          {NPORTS{cfg_r[`HPS_CFG_INV_PRESENCE]}});
  assign fault_act = ~(power_fault_input ^
                       {NPORTS{cfg_r[`HPS_CFG_INV_FAULT]}});
  assign latch_act = ~(retention_latch_sensor_input ^
                       {NPORTS{cfg_r[`HPS_CFG_INV_LATCH]}});
  assign pgood_act = ~(slot_power_good_input ^
                       {NPORTS{cfg_r[`HPS_CFG_INV_PGOOD]}});
  // In lock mode the sensor is no latch, so it never removes power
  assign latch_open = latch_act & {NPORTS{~cfg_r[`HPS_CFG_LATCH_AS_LOCK]}};
  assign lock_engaged = latch_act & {NPORTS{cfg_r[`HPS_CFG_LATCH_AS_LOCK]}};

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : g_port
      logic auto_off;
      assign auto_off = cfg_r[`HPS_CFG_LATCH_PWR_OFF] &&
                        ctl_r[`HPS_CTL_LATCHP_LO + g] && latch_open[g];
      // Auto power-off overrides whatever the software power bit holds
      assign want_power[g] = ctl_r[`HPS_CTL_PCC_LO + g] && !auto_off;

      hps_slot_port u_slot (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(tick_r),
        .rst_src(cfg_r[`HPS_CFG_RST_SRC_HI:`HPS_CFG_RST_SRC_LO]),
        .p2r_delay(cfg_r[`HPS_CFG_P2R_HI:`HPS_CFG_P2R_LO]),
        .r2p_delay(cfg_r[`HPS_CFG_R2P_HI:`HPS_CFG_R2P_LO]),
        .ilock_toggle(cfg_r[`HPS_CFG_ILOCK_TOGGLE]),
        .want_power(want_power[g]),
        .power_good(pgood_act[g]),
        .hot_reset(ctl_r[`HPS_CTL_HOTRST_LO + g]),
        .ilock_cmd(eic_r[g]),
        .power_on(power_on[g]),
        .reset_active(reset_active[g]),
        .ilock_level(ilock_level[g])
      );
    end
  endgenerate

  // Indicators are active low, enables active high, before any inversion
  always_comb begin
    attn_pin_nxt = ~(ctl_r[`HPS_CTL_ATTN_LO +: NPORTS]) ^
                   {NPORTS{cfg_r[`HPS_CFG_INV_ATTN]}};
    pind_pin_nxt = ~power_on ^ {NPORTS{cfg_r[`HPS_CFG_INV_PWR_IND]}};
    pen_pin_nxt = power_on ^ {NPORTS{cfg_r[`HPS_CFG_INV_PWR_EN]}};
    ilock_pin_nxt = ilock_level ^ {NPORTS{cfg_r[`HPS_CFG_INV_ILOCK]}};
    prst_n_nxt = ~reset_active;
  end

  // Pins idle with power off and reset asserted during reset
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      attn_pin_r <= '1;
      pind_pin_r <= '1;
      pen_pin_r <= '0;
      ilock_pin_r <= '0;
      prst_n_r <= '0;
    end else begin
      attn_pin_r <= attn_pin_nxt;
      pind_pin_r <= pind_pin_nxt;
      pen_pin_r <= pen_pin_nxt;
      ilock_pin_r <= ilock_pin_nxt;
      prst_n_r <= prst_n_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign attention_indicator_output = attn_pin_r;
  assign power_indicator_output = pind_pin_r;
  assign slot_power_enable_output = pen_pin_r;
  assign interlock_drive_output = ilock_pin_r;
  assign port_reset_n = prst_n_r;
endmodule : hps_pin_ctrl

// File: hps_slot_model.sv
// Slot power supply model answering power enable with a delayed power good
module hps_slot_model #(
  parameter int NPORTS = 2,
  parameter int DLY = 5
) (
  // Clock
  input wire logic sys_clk,
  // Board polarity and enable pins
  input wire logic pen_inv,
  input wire logic pg_inv,
  input wire logic [NPORTS-1:0] pen_pin,
  // Power good pins
  output logic [NPORTS-1:0] pg_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt [NPORTS];
  initial pg_pin = '1;
  // Supply reports good only after DLY cycles of steady enable, never at once
  always @(posedge sys_clk) begin
    for (int p = 0; p < NPORTS; p++) begin
      cnt[p] <= (pen_pin[p] ^ pen_inv) ? ((cnt[p] < DLY) ? cnt[p] + 1 : DLY) : 0;
      pg_pin[p] <= ~((cnt[p] == DLY) ^ pg_inv);
    end
  end
endmodule : hps_slot_model

// File: hps_pin_ctrl_sva.sv
// Port assertions for the slot pin block
module hps_chk #(
  parameter int NPORTS = 6,
  parameter int ADDR_W = 12
) (
  // Clock, reset and bus
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Slot pins
  input wire logic [NPORTS-1:0] slot_power_enable_output,
  input wire logic [NPORTS-1:0] interlock_drive_output,
  input wire logic [NPORTS-1:0] port_reset_n
);
  logic mapped;
  assign mapped = paddr inside {12'h408, 12'h500, 12'h504, 12'h508, 12'h50c};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence acc_start;
    psel && penable && !$past(penable);
  endsequence
  sequence wait_ready;
    !pready ##1 pready;
  endsequence
  one_wait_a: assert property (acc_start |-> wait_ready)
    else $error("ready not in second access cycle");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  idle_ready_a: assert property (!psel |-> !pready) else $error("ready while idle");
  err_map_a: assert property (pready |-> (pslverr == !mapped)) else $error("bad slave error");
  reset_pins_a: assert property (disable iff (1'b0) rst |=>
    (slot_power_enable_output == '0 && interlock_drive_output == '0 && port_reset_n == '0))
    else $error("pins wrong in reset");
  rel_stable_a: assert property ($rose(port_reset_n[0]) |->
    $past(slot_power_enable_output[0], 3) == slot_power_enable_output[0])
    else $error("reset released before power stable");
  rel_hold_a: assert property ($rose(port_reset_n[0]) |=> port_reset_n[0] [*2])
    else $error("reset release glitch");
  pwr_order_a: assert property (((slot_power_enable_output ^
    $past(slot_power_enable_output)) & port_reset_n) == '0)
    else $error("power changed with reset released");
endmodule : hps_chk
bind hps_pin_ctrl hps_chk #(.NPORTS(NPORTS), .ADDR_W(ADDR_W)) chk_i (.sys_clk, .rst, .psel,
  .penable, .paddr, .pready, .pslverr, .slot_power_enable_output, .interlock_drive_output,
  .port_reset_n);

// File: tb_top.sv
// Self-checking bench for the slot pin block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NP = 2;
  localparam int TK = 10;
  typedef struct {logic [31:0] cfg; logic [4:0] pins; logic [4:0] sts; logic [3:0] outs;} hps_row_s;
  hps_row_s rows [4] = '{'{32'h0000_0000, 5'h1f, 5'h00, 4'hc},
    '{32'h0000_000f, 5'h1f, 5'h1e, 4'hc}, '{32'h0000_00f0, 5'h00, 5'h1e, 4'h3},
    '{32'h0000_0105, 5'h06, 5'h0c, 4'hc}};
  logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq, sq, cfg_now;
  logic [3:0] pstrb;
  logic [NP-1:0] btn, pres, flt, lat, pg, attn, pind, pen, ilk, prst_n;
  int err_total, checked, cyc, n, w;
  hps_pin_ctrl #(.NPORTS(NP), .TICK_CYCLES(TK), .ADDR_W(12)) dut (.sys_clk(sys_clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .attention_button_input(btn), .presence_detect_input(pres), .power_fault_input(flt),
    .retention_latch_sensor_input(lat), .slot_power_good_input(pg),
    .attention_indicator_output(attn), .power_indicator_output(pind),
    .slot_power_enable_output(pen), .interlock_drive_output(ilk), .port_reset_n(prst_n));
  hps_slot_model #(.NPORTS(NP), .DLY(5)) slot (.sys_clk(sys_clk), .pen_inv(cfg_now[6]),
    .pg_inv(cfg_now[8]), .pen_pin(pen), .pg_pin(pg));
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Ceiling well above the several hundred cycles the tests need
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > 30000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic chkw(input string nm, input int lo, input int hi, input int g);
    checked++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask : chkw
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    // Ends when pready rises; if it never does, only the bench timeout ends this wait
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge sys_clk);
  endtask : apb
  task automatic wt(input int s, input logic v, output int k);
    k = 0;
    while (((s == 0) ? pen[0] : (s == 1) ? prst_n[0] : ilk[0]) !== v && k < 3000) begin
      @(posedge sys_clk);
      k++;
    end
  endtask : wt
  initial begin
    rst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    btn = '1;
    pres = '1;
    flt = '1;
    lat = '1;
    cfg_now = 32'h1414_0800;
    repeat (4) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    apb(0, 12'h408, 0);
    chk("cfg reset", 32'h1414_0800, rq);
    apb(0, 12'h400, 0);
    chk("unmapped err", 32'h1, {31'h0, re});
    chk("unmapped data", 32'h0, rq);
    foreach (rows[i]) begin
      apb(1, 12'h408, rows[i].cfg);
      cfg_now <= rows[i].cfg;
      {btn, pres, flt, lat} <= {{NP{rows[i].pins[4]}}, {NP{rows[i].pins[3]}},
        {NP{rows[i].pins[2]}}, {NP{rows[i].pins[1]}}};
      // Sense pins and the supply model need a few cycles to settle
      repeat (10) @(posedge sys_clk);
      apb(0, 12'h508, 0);
      sq = rq;
      apb(0, 12'h50c, 0);
      chk("status", rows[i].sts, {sq[0], sq[8], sq[16], sq[24], rq[0]});
      chk("outs", rows[i].outs, {attn[0], pind[0], pen[0], ilk[0]});
    end
    cfg_now <= 32'h0;
    for (int s = 0; s < 4; s++) begin
      apb(1, 12'h408, {8'h01, 8'h02, 2'(s), 3'b001, 11'h0});
      apb(1, 12'h500, (s == 2) ? 32'h0100_0101 : 32'h0000_0101);
      wt(0, 1, n);
      if (s == 2) begin
        repeat (40) @(posedge sys_clk);
        chk("hot hold", 32'h0, {31'h0, prst_n[0]});
        apb(1, 12'h500, 32'h0000_0101);
      end
      wt(1, 1, n);
      chkw("p2r", (s == 2) ? 0 : TK + ((s == 1) ? 5 : 0), 2 * TK + 6 + ((s == 1) ? 8 : 0), n);
      lat <= '0;
      wt(1, 0, n);
      chkw("latch reset", 0, 6, n);
      wt(0, 0, n);
      chkw("r2p", 0, TK + 6, n);
      apb(1, 12'h408, {8'h01, 8'h02, 2'(s), 3'b011, 11'h0});
      wt(0, 1, n);
      chkw("lock mode", 0, 10, n);
      lat <= '1;
      apb(1, 12'h500, 0);
      wt(1, 0, n);
      wt(0, 0, n);
    end
    apb(1, 12'h408, 32'h0000_0800);
    apb(1, 12'h504, 32'h1);
    wt(2, 1, n);
    wt(2, 0, w);
    chkw("pulse", 12 * TK, 13 * TK + 4, w);
    apb(1, 12'h408, 32'h0000_2800);
    for (int t = 0; t < 2; t++) begin
      apb(1, 12'h504, 32'h1);
      repeat (4) @(posedge sys_clk);
      chk("toggle", 32'(1 - t), {31'h0, ilk[0]});
    end
    apb(1, 12'h408, 32'h0002_0800);
    apb(1, 12'h500, 32'h0000_0001);
    lat <= '0;
    wt(0, 1, n);
    repeat (30) @(posedge sys_clk);
    chk("no latchp", 32'h1, {31'h0, pen[0]});
    lat <= '1;
    apb(1, 12'h500, 0);
    wt(0, 0, n);
    apb(1, 12'h408, 32'h1414_0e00);
    apb(0, 12'h408, 0);
    chk("reserved", 32'h1414_0e00, rq);
    summarize();
  end
endmodule : tb_top
